//--- testbench/nta_ctrl_monitor.sv
/*
 * Checker for the attribute-block writer: register answer timing and the
 * shape of each block write frame on the byte link.
 * Assumes it is bound to the writer's top module and sees its ports only.
 */
module nta_ctrl_monitor #(
	parameter [18:0] RESP_TIMEOUT_CYCLES = 19'd200
) (
	input wire i_ref_clk,
	input wire i_reset_n,
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire o_wb_ack,
	input wire [7:0] o_tx_data,
	input wire o_tx_valid,
	input wire o_tx_last,
	input wire i_tx_ready
);
	reg [4:0] pos_reg;
	reg [7:0] blk_reg;
	wire acc = o_tx_valid && i_tx_ready;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	// byte position within the frame and the block number it names
	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pos_reg <= 5'd0;
			blk_reg <= 8'h00;
		end
		else if (acc)
		begin
			pos_reg <= o_tx_last ? 5'd0 : pos_reg + 5'd1;
			if (pos_reg == 5'd14)
				blk_reg <= o_tx_data;
		end
	end
	sequence req_s;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence gap_s;
		!o_tx_valid ##1 !o_tx_valid ##1 o_tx_valid;
	endsequence
	wb_ack_prompt_a: assert property (req_s |=> o_wb_ack) else $error("no ack after request");
	wb_ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
	tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
		else $error("byte changed before accept");
	byte_gap_a: assert property (acc && !o_tx_last |=> gap_s) else $error("next byte not three cycles after accept");
	frame_code_a: assert property (o_tx_valid && pos_reg == 5'd0 |-> o_tx_data == 8'h08)
		else $error("frame does not open with write code");
	frame_last_a: assert property (o_tx_valid |-> o_tx_last == (pos_reg == 5'd30))
		else $error("last flag not on byte 30");
	block_range_a: assert property (o_tx_valid && pos_reg == 5'd14 |-> o_tx_data <= 8'd23)
		else $error("block number beyond file area");
	read_limit_a: assert property (o_tx_valid && pos_reg == 5'd16 && blk_reg == 8'h00 |-> o_tx_data == 8'h0F)
		else $error("read limit byte wrong");
	write_limit_a: assert property (o_tx_valid && pos_reg == 5'd17 && blk_reg == 8'h00 |-> o_tx_data == 8'h0B)
		else $error("write limit byte wrong");
	unused_zero_a: assert property (o_tx_valid && blk_reg == 8'h00 && pos_reg >= 5'd20 && pos_reg <= 5'd23
		|-> o_tx_data == 8'h00) else $error("unused attribute byte not zero");
endmodule

//--- testbench/nta_tag_model.sv
/*
 * Tag model: takes 31-byte block write frames, keeps 24 blocks of data
 * and answers each frame with the short write response unless i_mute is set.
 * Assumes the writer holds each byte until ready and awaits each answer.
 */
module nta_tag_model #(
	parameter [63:0] CARD_ID = 64'h5A5A_0123_4567_89AB // arbitrary value
) (
	input wire i_ref_clk,
	input wire i_reset_n,
	input wire [7:0] i_tx_data,
	input wire i_tx_valid,
	input wire i_tx_last,
	output wire o_tx_ready,
	output reg [7:0] o_rx_data,
	output reg o_rx_valid,
	output reg o_rx_last,
	input wire i_ready_en,
	input wire [3:0] i_delay,
	input wire i_mute
);
	reg [7:0] mem [0:383];
	reg [7:0] frm [0:30];
	reg [4:0] idx;
	reg [3:0] wait_cnt, rsp;
	reg busy;
	// verdict fixed when the frame ends, so a write to block 0 cannot alter its own answer
	reg ok_reg;
	reg [7:0] flag_prev, flag_last;
	integer k;
	// block 0 refuses writes once its access byte holds read-only
	wire ok = frm[0] == 8'h08 && frm[14] <= 8'd23 && !(frm[14] == 8'h00 && mem[10] == 8'h00);
	wire [87:0] resp = {8'h09, CARD_ID, ok_reg ? 8'h00 : 8'h01, 8'h00};
	assign o_tx_ready = i_ready_en && !busy;
	initial
	begin
		for (k = 0; k < 384; k = k + 1)
			mem[k] = 8'hFF;
	end
	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			idx <= 5'd0;
			busy <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_last <= 1'b0;
			o_rx_data <= 8'hA5;
		end
		else
		begin
			o_rx_valid <= 1'b0;
			o_rx_last <= 1'b0;
			// idle data lines toggle so a stale byte never looks valid
			o_rx_data <= ~o_rx_data;
			if (i_tx_valid && o_tx_ready)
			begin
				frm[idx] <= i_tx_data;
				idx <= i_tx_last ? 5'd0 : idx + 5'd1;
				busy <= i_tx_last;
				if (i_tx_last)
					ok_reg <= ok;
				wait_cnt <= i_delay;
				rsp <= 4'd0;
			end
			else if (busy && i_mute)
				busy <= 1'b0;
			else if (busy && wait_cnt != 4'd0)
				wait_cnt <= wait_cnt - 4'd1;
			else if (busy)
			begin
				o_rx_valid <= 1'b1;
				o_rx_data <= resp[8 * (10 - rsp) +: 8];
				o_rx_last <= rsp == 4'd10;
				busy <= rsp != 4'd10;
				rsp <= rsp + 4'd1;
				if (rsp == 4'd0 && ok_reg)
				begin
					for (k = 0; k < 16; k = k + 1)
						mem[frm[14] * 16 + k] <= frm[15 + k];
					if (frm[14] == 8'h00)
					begin
						flag_prev <= flag_last;
						flag_last <= frm[24];
					end
				end
			end
		end
	end
endmodule

//--- testbench/tb_top.sv
/*
 * Bench for the attribute-block writer: drives its registers over Wishbone,
 * lets the tag model answer and checks what the tag stored.
 * Assumes the checker and tag model files are compiled before this one.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [63:0] CARD_ID = 64'h5A5A_0123_4567_89AB; // arbitrary value
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ready_en = 1'b0, mute = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, junk;
	logic [3:0] sel = 4'h0, delay = 4'h0;
	logic [15:0] lfsr = 16'd39003;
	logic [7:0] buf_mem [0:367];
	wire [31:0] rdat;
	wire ack, txv, txl, txr, rxv, rxl;
	wire [7:0] txd, rxd;
	integer fails = 0, num_checks = 0, cycles = 0;
	always #12.5 clk = ~clk;
	nta_ctrl #(.RESP_TIMEOUT_CYCLES(19'd200)) dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
		.o_wb_ack(ack), .o_tx_data(txd), .o_tx_valid(txv), .o_tx_last(txl), .i_tx_ready(txr),
		.i_rx_data(rxd), .i_rx_valid(rxv), .i_rx_last(rxl));
	nta_tag_model #(.CARD_ID(CARD_ID)) tag (.i_ref_clk(clk), .i_reset_n(rst_n), .i_tx_data(txd),
		.i_tx_valid(txv), .i_tx_last(txl), .o_tx_ready(txr), .o_rx_data(rxd), .o_rx_valid(rxv),
		.o_rx_last(rxl), .i_ready_en(ready_en), .i_delay(delay), .i_mute(mute));
	function automatic [15:0] lfsr_step(input [15:0] s);
		lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic [2:0] exp_err(input [15:0] sc, input [15:0] cap, input [1:0] mode, input [23:0] nblk);
		logic [15:0] lim;
		lim = mode == 2'd1 ? 16'h001A : mode == 2'd2 ? 16'h0018 : 16'h0017;
		exp_err = (sc != 16'h12FC || cap > lim || cap > 16'd23 || nblk == 0 || cap < nblk) ? 3'h1 : 3'h0;
	endfunction
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		lfsr <= lfsr_step(lfsr);
		ready_en <= lfsr[0] | lfsr[1];
		delay <= lfsr[7:4];
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			fails = fails + 1;
			final_report;
		end
	end
	task check(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; the next call waits an edge, so cyc stays low a cycle
	task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task run(input [31:0] ctrl, output [31:0] st);
		wb(1'b1, 8'h00, ctrl, junk);
		st = 32'h1;
		while (st[0] !== 1'b0)
			wb(1'b0, 8'h20, 32'h0, st);
	endtask
	task setup(input [15:0] sc, input [15:0] cap, input [7:0] ver, input [23:0] len);
		wb(1'b1, 8'h14, {16'h0, sc}, junk);
		wb(1'b1, 8'h04, {cap, 8'h00, ver}, junk);
		wb(1'b1, 8'h08, {8'h00, len}, junk);
	endtask
	task check_tag(input [7:0] ver, input [15:0] cap, input [23:0] len, input fmt, input [23:0] nblk);
		logic [127:0] b;
		logic [15:0] sum;
		integer k;
		b = {ver, 8'h0F, 8'h0B, cap, 32'h0, 8'h00, 8'h01, fmt ? 24'h3 : len, 16'h0};
		sum = 16'h0;
		for (k = 0; k < 14; k = k + 1)
			sum = sum + b[127 - 8 * k -: 8];
		b[15:0] = sum;
		for (k = 0; k < 16; k = k + 1)
			check(tag.mem[k], b[127 - 8 * k -: 8]);
		for (k = 0; k < nblk * 16; k = k + 1)
			check(tag.mem[16 + k], fmt ? (k == 0 ? 8'hD0 : 8'h00) : buf_mem[k]);
		check({tag.flag_prev, tag.flag_last}, 16'h0F00);
	endtask
	initial
	begin
		logic [31:0] st;
		logic [15:0] r, sc, cap;
		logic [23:0] len, nblk;
		logic [1:0] mode;
		logic fmt;
		integer i;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, 8'h04, 32'h0, st);
		check(st, 32'h0017_0010);
		wb(1'b0, 8'h3C, 32'h0, st);
		check(st, 32'h0);
		wb(1'b1, 8'h0C, CARD_ID[63:32], junk);
		wb(1'b1, 8'h10, CARD_ID[31:0], junk);
		wb(1'b1, 8'h18, 32'h0, junk);
		for (i = 0; i < 368; i = i + 1)
		begin
			buf_mem[i] = lfsr[7:0];
			wb(1'b1, 8'h1C, {24'h0, lfsr[7:0]}, junk);
		end
		for (i = 0; i < 9; i = i + 1)
		begin
			r = lfsr;
			mode = r[1:0];
			fmt = r[2];
			sc = r[5:3] == 3'd0 ? 16'h12FD : 16'h12FC;
			cap = 16'd1 + r[15:8] % 26;
			@(posedge clk);
			len = lfsr % (cap * 16 + 8);
			// first pass fills the whole file area
			if (i == 0)
			begin
				mode = 2'd0;
				fmt = 1'b0;
				sc = 16'h12FC;
				cap = 16'd23;
				len = 24'd368;
			end
			nblk = fmt ? 24'd1 : (len + 24'd15) / 24'd16;
			setup(sc, cap, r[15:8], len);
			run({23'h0, 1'b1, 4'h0, mode, fmt, ~fmt}, st);
			check(st[4:2], exp_err(sc, cap, mode, nblk));
			check(st[1], exp_err(sc, cap, mode, nblk) == 3'h0);
			if (exp_err(sc, cap, mode, nblk) == 3'h0)
				check_tag(r[15:8], cap, len, fmt, nblk);
		end
		setup(16'h12FC, 16'd1, 8'h10, 24'd3);
		mute <= 1'b1;
		run(32'h0000_0102, st);
		check(st[4:2], 3'h5);
		check(st[1], 1'b0);
		mute <= 1'b0;
		wb(1'b1, 8'h0C, ~CARD_ID[63:32], junk);
		run(32'h0000_0102, st);
		check(st[4:2], 3'h3);
		wb(1'b1, 8'h0C, CARD_ID[63:32], junk);
		run(32'h0000_0002, st);
		check(st[4:2], 3'h4);
		check(st[15:8], 8'h01);
		final_report;
	end
endmodule
bind nta_ctrl nta_ctrl_monitor #(.RESP_TIMEOUT_CYCLES(RESP_TIMEOUT_CYCLES)) mon (.i_ref_clk(i_ref_clk),
	.i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
	.o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready));

//--- verilog/nta_ctrl.v
/*
 * Reader-side writer of an NDEF file: formats the attribute block, sends one
 * block write command per block and checks each write response.
 * Assumes a byte link to the RF front end that frames and codes each command,
 * and a classic Wishbone master for the registers.
 */
`include "nta_regs.vh"

module nta_ctrl #(
	parameter [18:0] RESP_TIMEOUT_CYCLES = `NTA_RESP_TIMEOUT_US * `NTA_CLK_MHZ
) (
	input wire i_ref_clk,
	input wire i_reset_n,
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [31:0] i_wb_dat,
	input wire [3:0] i_wb_sel,
	output reg [31:0] o_wb_dat,
	output reg o_wb_ack,
	output reg [7:0] o_tx_data,
	output reg o_tx_valid,
	output reg o_tx_last,
	input wire i_tx_ready,
	input wire [7:0] i_rx_data,
	input wire i_rx_valid,
	input wire i_rx_last
);

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_FETCH = 3'd1;
	localparam [2:0] ST_LOAD = 3'd2;
	localparam [2:0] ST_PUSH = 3'd3;
	localparam [2:0] ST_RESP = 3'd4;
	localparam [2:0] ST_NEXT = 3'd5;

	localparam [1:0] PH_AIB_OPEN = 2'd0;
	localparam [1:0] PH_DATA = 2'd1;
	localparam [1:0] PH_AIB_CLOSE = 2'd2;

	reg [1:0] mode_reg;
	reg rw_reg;
	reg [7:0] version_reg;
	reg [15:0] capacity_reg;
	reg [23:0] length_reg;
	reg [63:0] id_reg;
	reg [15:0] syscode_reg;
	reg [8:0] buf_addr_reg;
	reg done_reg;
	reg [2:0] err_reg;
	reg [7:0] flag1_reg;
	reg [7:0] flag2_reg;
	reg [2:0] state_reg;
	reg [1:0] phase_reg;
	reg [4:0] blk_reg;
	reg [4:0] nblk_reg;
	reg format_reg;
	reg [4:0] pos_reg;
	reg [3:0] rx_pos_reg;
	reg bad_code_reg;
	reg bad_id_reg;
	reg [18:0] timer_reg;

	wire [7:0] mem_rdata;
	wire wb_hit = i_wb_cyc & i_wb_stb & o_wb_ack;
	wire wb_wr = wb_hit & i_wb_we;
	wire [7:0] wb_ofs = {i_wb_adr[7:2], 2'b00};
	wire busy = (state_reg != ST_IDLE);
	wire buf_we = wb_wr & (wb_ofs == `NTA_OFS_BUF_DATA) & i_wb_sel[0] & ~busy;
	wire start_req = wb_wr & (wb_ofs == `NTA_OFS_CTRL) & i_wb_sel[0] & ~busy &
		(i_wb_dat[`NTA_CTRL_START] | i_wb_dat[`NTA_CTRL_FORMAT]);
	wire start_fmt = i_wb_dat[`NTA_CTRL_FORMAT];

	// write-merge by byte lane
	function [31:0] wb_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] sel;
		begin
			wb_merge = (old_val & ~{{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}}) |
				(new_val & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}});
		end
	endfunction

	wire [31:0] cfg_merged = wb_merge({capacity_reg, 16'd0}, i_wb_dat, i_wb_sel);
	wire [31:0] len_merged = wb_merge({8'd0, length_reg}, i_wb_dat, i_wb_sel);
	wire [31:0] sys_merged = wb_merge({16'd0, syscode_reg}, i_wb_dat, i_wb_sel);
	wire [31:0] addr_merged = wb_merge({23'd0, buf_addr_reg}, i_wb_dat, i_wb_sel);

	// block count of the message, rounded up to whole blocks
	wire [19:0] len_blocks = length_reg[23:4] + {19'd0, |length_reg[3:0]};
	reg [15:0] cap_limit;
	// a start write carries the mode of its own pass, so the check uses that field
	always @*
	begin
		case (i_wb_dat[`NTA_CTRL_MODE_HI:`NTA_CTRL_MODE_LO])
			`NTA_MODE_BLOCK_ONLY: cap_limit = `NTA_CAP_BLOCK_ONLY;
			`NTA_MODE_ENCRYPTED: cap_limit = `NTA_CAP_ENCRYPTED;
			default: cap_limit = `NTA_CAP_SHARED;
		endcase
	end
	wire [19:0] need_blocks = start_fmt ? 20'd1 : len_blocks;
	wire cfg_ok = (syscode_reg == `NTA_SYSCODE_NDEF) &&
		(capacity_reg <= cap_limit) && (capacity_reg <= {11'd0, `NTA_FILE_BLOCKS}) &&
		(need_blocks != 20'd0) && ({4'd0, capacity_reg} >= need_blocks);

	// attribute block built from the settings of the current pass
	wire [23:0] aib_len = format_reg ? `NTA_EMPTY_LEN : length_reg;
	wire [7:0] aib_flag = (phase_reg == PH_AIB_CLOSE) ? `NTA_FLAG_DONE : `NTA_FLAG_BUSY;
	wire [7:0] aib_rw = {7'd0, rw_reg};
	wire [15:0] aib_sum = {8'd0, version_reg} + {8'd0, `NTA_AIB_NBR} + {8'd0, `NTA_AIB_NBW} +
		{8'd0, capacity_reg[15:8]} + {8'd0, capacity_reg[7:0]} + {8'd0, aib_flag} +
		{8'd0, aib_rw} + {8'd0, aib_len[23:16]} + {8'd0, aib_len[15:8]} +
		{8'd0, aib_len[7:0]};

	wire [4:0] data_full = pos_reg - `NTA_POS_DATA;
	wire [3:0] data_idx = data_full[3:0];
	wire [4:0] blk_prev = blk_reg - 5'd1;
	wire [8:0] mem_raddr = {blk_prev, data_idx};
	wire [4:0] id_full = pos_reg - 5'd1;
	wire [63:0] id_shift = id_reg << {id_full[2:0], 3'b000};

	reg [7:0] aib_byte;
	always @*
	begin
		case (data_idx)
			4'd0: aib_byte = version_reg;
			4'd1: aib_byte = `NTA_AIB_NBR;
			4'd2: aib_byte = `NTA_AIB_NBW;
			4'd3: aib_byte = capacity_reg[15:8];
			4'd4: aib_byte = capacity_reg[7:0];
			4'd9: aib_byte = aib_flag;
			4'd10: aib_byte = aib_rw;
			4'd11: aib_byte = aib_len[23:16];
			4'd12: aib_byte = aib_len[15:8];
			4'd13: aib_byte = aib_len[7:0];
			4'd14: aib_byte = aib_sum[15:8];
			4'd15: aib_byte = aib_sum[7:0];
			default: aib_byte = 8'h00;
		endcase
	end

	wire [23:0] empty_msg = `NTA_EMPTY_MSG;
	reg [7:0] data_byte;
	always @*
	begin
		if (phase_reg != PH_DATA)
		begin
			data_byte = aib_byte;
		end
		else if (format_reg)
		begin
			case (data_idx)
				4'd0: data_byte = empty_msg[23:16];
				4'd1: data_byte = empty_msg[15:8];
				4'd2: data_byte = empty_msg[7:0];
				default: data_byte = 8'h00;
			endcase
		end
		else
		begin
			data_byte = mem_rdata;
		end
	end

	reg [7:0] frame_byte;
	always @*
	begin
		if (pos_reg == 5'd0)
			frame_byte = `NTA_CMD_WRITE;
		else if (pos_reg < `NTA_POS_SVC_CNT)
			frame_byte = id_shift[63:56];
		else if (pos_reg == 5'd9)
			frame_byte = `NTA_SVC_COUNT;
		else if (pos_reg == 5'd10)
			frame_byte = `NTA_SVC_HI;
		else if (pos_reg == 5'd11)
			frame_byte = `NTA_SVC_LO;
		else if (pos_reg == 5'd12)
			frame_byte = `NTA_BLK_COUNT;
		else if (pos_reg == 5'd13)
			frame_byte = `NTA_BLK_ELEM_HI;
		else if (pos_reg == 5'd14)
			frame_byte = {3'd0, blk_reg};
		else
			frame_byte = data_byte;
	end

	// identifier byte expected at each response position
	wire [3:0] rx_id_full = rx_pos_reg - 4'd1;
	wire [63:0] rx_id_shift = id_reg << {rx_id_full[2:0], 3'b000};

	nta_msg_mem u_mem (
		.i_ref_clk(i_ref_clk),
		.i_we(buf_we),
		.i_waddr(buf_addr_reg),
		.i_wdata(i_wb_dat[7:0]),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);

	// register slave: ack one cycle after the request, write at the ack edge
	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
			mode_reg <= `NTA_MODE_SHARED;
			rw_reg <= `NTA_RST_RW;
			version_reg <= `NTA_RST_VERSION;
			capacity_reg <= `NTA_RST_CAPACITY;
			length_reg <= 24'h000000;
			id_reg <= 64'h0000000000000000;
			syscode_reg <= 16'h0000;
			buf_addr_reg <= 9'h000;
		end
		else
		begin
			o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
			if (i_wb_cyc & i_wb_stb & ~o_wb_ack)
			begin
				case ({i_wb_adr[7:2], 2'b00})
					`NTA_OFS_CTRL: o_wb_dat <= {23'd0, rw_reg, 4'd0, mode_reg, 2'd0};
					`NTA_OFS_CFG: o_wb_dat <= {capacity_reg, 8'd0, version_reg};
					`NTA_OFS_LEN: o_wb_dat <= {8'd0, length_reg};
					`NTA_OFS_ID_HI: o_wb_dat <= id_reg[63:32];
					`NTA_OFS_ID_LO: o_wb_dat <= id_reg[31:0];
					`NTA_OFS_SYSCODE: o_wb_dat <= {16'd0, syscode_reg};
					`NTA_OFS_BUF_ADDR: o_wb_dat <= {23'd0, buf_addr_reg};
					`NTA_OFS_STATUS: o_wb_dat <= {8'd0, flag2_reg, flag1_reg, 3'd0, err_reg, done_reg, busy};
					default: o_wb_dat <= 32'h00000000;
				endcase
			end
			// settings are frozen while a pass runs
			if (wb_wr & ~busy)
			begin
				case (wb_ofs)
					`NTA_OFS_CTRL:
					begin
						if (i_wb_sel[0])
							mode_reg <= i_wb_dat[`NTA_CTRL_MODE_HI:`NTA_CTRL_MODE_LO];
						if (i_wb_sel[1])
							rw_reg <= i_wb_dat[`NTA_CTRL_RW];
					end
					`NTA_OFS_CFG:
					begin
						if (i_wb_sel[0])
							version_reg <= i_wb_dat[7:0];
						capacity_reg <= cfg_merged[31:16];
					end
					`NTA_OFS_LEN: length_reg <= len_merged[23:0];
					`NTA_OFS_ID_HI: id_reg[63:32] <= wb_merge(id_reg[63:32], i_wb_dat, i_wb_sel);
					`NTA_OFS_ID_LO: id_reg[31:0] <= wb_merge(id_reg[31:0], i_wb_dat, i_wb_sel);
					`NTA_OFS_SYSCODE: syscode_reg <= sys_merged[15:0];
					`NTA_OFS_BUF_ADDR: buf_addr_reg <= addr_merged[8:0];
					`NTA_OFS_BUF_DATA:
					begin
						if (i_wb_sel[0])
							buf_addr_reg <= buf_addr_reg + 9'd1;
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	// sequencer: open attribute block, file blocks, close attribute block
	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_AIB_OPEN;
			blk_reg <= 5'd0;
			nblk_reg <= 5'd0;
			format_reg <= 1'b0;
			pos_reg <= 5'd0;
			rx_pos_reg <= 4'd0;
			bad_code_reg <= 1'b0;
			bad_id_reg <= 1'b0;
			timer_reg <= 19'd0;
			done_reg <= 1'b0;
			err_reg <= `NTA_ERR_NONE;
			flag1_reg <= 8'h00;
			flag2_reg <= 8'h00;
			o_tx_data <= 8'h00;
			o_tx_valid <= 1'b0;
			o_tx_last <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (start_req)
					begin
						done_reg <= 1'b0;
						format_reg <= start_fmt;
						nblk_reg <= need_blocks[4:0];
						phase_reg <= PH_AIB_OPEN;
						blk_reg <= 5'd0;
						pos_reg <= 5'd0;
						if (cfg_ok)
						begin
							err_reg <= `NTA_ERR_NONE;
							state_reg <= ST_FETCH;
						end
						else
						begin
							err_reg <= `NTA_ERR_CONFIG;
						end
					end
				end
				ST_FETCH: state_reg <= ST_LOAD;
				ST_LOAD:
				begin
					o_tx_data <= frame_byte;
					o_tx_valid <= 1'b1;
					o_tx_last <= (pos_reg == `NTA_POS_LAST);
					state_reg <= ST_PUSH;
				end
				ST_PUSH:
				begin
					if (i_tx_ready)
					begin
						o_tx_valid <= 1'b0;
						o_tx_last <= 1'b0;
						if (pos_reg == `NTA_POS_LAST)
						begin
							rx_pos_reg <= 4'd0;
							bad_code_reg <= 1'b0;
							bad_id_reg <= 1'b0;
							timer_reg <= 19'd0;
							state_reg <= ST_RESP;
						end
						else
						begin
							pos_reg <= pos_reg + 5'd1;
							state_reg <= ST_FETCH;
						end
					end
				end
				ST_RESP:
				begin
					timer_reg <= timer_reg + 19'd1;
					if (i_rx_valid)
					begin
						rx_pos_reg <= rx_pos_reg + 4'd1;
						if (rx_pos_reg == 4'd0 && i_rx_data != `NTA_RESP_WRITE)
							bad_code_reg <= 1'b1;
						if (rx_pos_reg != 4'd0 && rx_pos_reg < 4'd9 && i_rx_data != rx_id_shift[63:56])
							bad_id_reg <= 1'b1;
						if (rx_pos_reg == 4'd9)
							flag1_reg <= i_rx_data;
						if (rx_pos_reg == `NTA_RESP_POS_LAST)
							flag2_reg <= i_rx_data;
						// the frame must end exactly on the second status flag
						if (i_rx_last != (rx_pos_reg == `NTA_RESP_POS_LAST))
						begin
							err_reg <= `NTA_ERR_FRAME;
							state_reg <= ST_IDLE;
						end
						else if (i_rx_last)
						begin
							if (bad_code_reg)
							begin
								err_reg <= `NTA_ERR_FRAME;
								state_reg <= ST_IDLE;
							end
							else if (bad_id_reg)
							begin
								err_reg <= `NTA_ERR_ID;
								state_reg <= ST_IDLE;
							end
							else if (flag1_reg != 8'h00)
							begin
								err_reg <= `NTA_ERR_STATUS;
								state_reg <= ST_IDLE;
							end
							else
							begin
								state_reg <= ST_NEXT;
							end
						end
					end
					else if (timer_reg == RESP_TIMEOUT_CYCLES)
					begin
						err_reg <= `NTA_ERR_TIMEOUT;
						state_reg <= ST_IDLE;
					end
				end
				ST_NEXT:
				begin
					pos_reg <= 5'd0;
					state_reg <= ST_FETCH;
					case (phase_reg)
						PH_AIB_OPEN:
						begin
							phase_reg <= PH_DATA;
							blk_reg <= 5'd1;
						end
						PH_DATA:
						begin
							if (blk_reg == nblk_reg)
							begin
								phase_reg <= PH_AIB_CLOSE;
								blk_reg <= 5'd0;
							end
							else
							begin
								blk_reg <= blk_reg + 5'd1;
							end
						end
						default:
						begin
							done_reg <= 1'b1;
							state_reg <= ST_IDLE;
						end
					endcase
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule

//--- verilog/nta_msg_mem.v
/*
 * Message buffer: 512 bytes, one write port, one read port whose data come
 * out of a register one edge after the address is presented.
 * Assumes writes and reads never target the same byte in the same cycle.
 */
module nta_msg_mem (
	input wire i_ref_clk,
	input wire i_we,
	input wire [8:0] i_waddr,
	input wire [7:0] i_wdata,
	input wire [8:0] i_raddr,
	output reg [7:0] o_rdata
);

	reg [7:0] mem [0:511];

	always @(posedge i_ref_clk)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule

//--- verilog/nta_regs.vh
/*
 * Constants for the NDEF attribute-block writer: register offsets, field
 * positions, frame bytes, attribute block layout and timing counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef NTA_REGS_VH
`define NTA_REGS_VH

// register byte offsets
`define NTA_OFS_CTRL 8'h00
`define NTA_OFS_CFG 8'h04
`define NTA_OFS_LEN 8'h08
`define NTA_OFS_ID_HI 8'h0C
`define NTA_OFS_ID_LO 8'h10
`define NTA_OFS_SYSCODE 8'h14
`define NTA_OFS_BUF_ADDR 8'h18
`define NTA_OFS_BUF_DATA 8'h1C
`define NTA_OFS_STATUS 8'h20

// control register fields
`define NTA_CTRL_START 0
`define NTA_CTRL_FORMAT 1
`define NTA_CTRL_MODE_LO 2
`define NTA_CTRL_MODE_HI 3
`define NTA_CTRL_RW 8

// capacity modes
`define NTA_MODE_SHARED 2'h0
`define NTA_MODE_BLOCK_ONLY 2'h1
`define NTA_MODE_ENCRYPTED 2'h2

// reset values
`define NTA_RST_VERSION 8'h10
`define NTA_RST_CAPACITY 16'h0017
`define NTA_RST_RW 1'b1

// error codes
`define NTA_ERR_NONE 3'h0
`define NTA_ERR_CONFIG 3'h1
`define NTA_ERR_FRAME 3'h2
`define NTA_ERR_ID 3'h3
`define NTA_ERR_STATUS 3'h4
`define NTA_ERR_TIMEOUT 3'h5

// command and response frame
`define NTA_CMD_WRITE 8'h08
`define NTA_RESP_WRITE 8'h09
`define NTA_SVC_COUNT 8'h01
`define NTA_SVC_HI 8'h09
`define NTA_SVC_LO 8'h00
`define NTA_BLK_COUNT 8'h01
`define NTA_BLK_ELEM_HI 8'h80
`define NTA_POS_SVC_CNT 5'd9
`define NTA_POS_DATA 5'd15
`define NTA_POS_LAST 5'd30
`define NTA_RESP_POS_LAST 4'd10

// attribute block contents
`define NTA_SYSCODE_NDEF 16'h12FC
`define NTA_AIB_NBR 8'h0F
`define NTA_AIB_NBW 8'h0B
`define NTA_CAP_SHARED 16'h0017
`define NTA_CAP_BLOCK_ONLY 16'h001A
`define NTA_CAP_ENCRYPTED 16'h0018
`define NTA_FLAG_BUSY 8'h0F
`define NTA_FLAG_DONE 8'h00
`define NTA_EMPTY_MSG 24'hD00000
`define NTA_EMPTY_LEN 24'h000003
`define NTA_FILE_BLOCKS 5'd23

// timing
`define NTA_CLK_MHZ 40
`define NTA_RESP_TIMEOUT_US 10000

`endif
